// ===== logic/adc_result_defines.vh
// Offsets, field positions, reset values and step counts of the result block
`ifndef ADC_RESULT_DEFINES_VH
`define ADC_RESULT_DEFINES_VH

// Register map (byte address within the block window)
`define RES_OFFSET_DUAL     4'h0
`define RES_ADDR_W          4
`define RES_RESET           32'h00000000

// Field layout of the dual-channel result word
`define RES_DATA_W          12
`define RES_A_LSB           0
`define RES_A_MSB           11
`define RES_A_OVERRUN_BIT   14
`define RES_A_VALID_BIT     15
`define RES_B_LSB           16
`define RES_B_MSB           27
`define RES_B_OVERRUN_BIT   30
`define RES_B_VALID_BIT     31

// Channel indices
`define CHAN_A              1'b0
`define CHAN_B              1'b1

// Cycles a trial code is held before the comparator is sampled;
// covers the two-flop synchroniser plus comparator settling
`define SAR_STEP_CYCLES     4

`endif

// ===== logic/sar_sequencer.v
// Successive-approximation sequencer: one 12-bit conversion per start
`include "adc_result_defines.vh"

module sar_sequencer #(
   parameter DATA_W     = `RES_DATA_W,
   parameter STEP_CYCLES = `SAR_STEP_CYCLES
) (
   input  wire              clk_i,
   input  wire              rst_i,
   input  wire              start_i,
   input  wire              cmp_i,
   output reg  [DATA_W-1:0] code_o,
   output reg               busy_o,
   output reg               done_o,
   output reg  [DATA_W-1:0] result_o
);

   localparam CNT_W = 8;
   localparam [31:0] STEP_LAST_W = STEP_CYCLES - 1;
   localparam [CNT_W-1:0] STEP_LAST = STEP_LAST_W[CNT_W-1:0];
   localparam BIT_W = 4;
   localparam [31:0] TOP_BIT_W = DATA_W - 1;
   localparam [BIT_W-1:0] TOP_BIT = TOP_BIT_W[BIT_W-1:0];

   localparam ST_IDLE = 1'b0;
   localparam ST_STEP = 1'b1;

   reg             state_q;
   reg [BIT_W-1:0] bit_q;
   reg [CNT_W-1:0] wait_q;
   reg [DATA_W-1:0] keep;

   // Trial code with the bit under test cleared when comparator is low
   always @* begin
      keep = code_o;
      if (!cmp_i) begin
         keep[bit_q] = 1'b0;
      end
   end

   // Binary search: set a bit, wait, keep or drop it, move one bit down
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q  <= ST_IDLE;
         bit_q    <= {BIT_W{1'b0}};
         wait_q   <= {CNT_W{1'b0}};
         code_o   <= {DATA_W{1'b0}};
         busy_o   <= 1'b0;
         done_o   <= 1'b0;
         result_o <= {DATA_W{1'b0}};
      end else begin
         done_o <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (start_i) begin
                  state_q <= ST_STEP;
                  bit_q   <= TOP_BIT;
                  wait_q  <= {CNT_W{1'b0}};
                  code_o  <= {1'b1, {(DATA_W-1){1'b0}}};
                  busy_o  <= 1'b1;
               end
            end
            ST_STEP: begin
               if (wait_q != STEP_LAST) begin
                  wait_q <= wait_q + 1'b1;
               end else begin
                  wait_q <= {CNT_W{1'b0}};
                  if (bit_q == {BIT_W{1'b0}}) begin
                     // Last decision made: hand the word over
                     result_o <= keep;
                     code_o   <= keep;
                     done_o   <= 1'b1;
                     busy_o   <= 1'b0;
                     state_q  <= ST_IDLE;
                  end else begin
                     code_o            <= keep;
                     code_o[bit_q - 1'b1] <= 1'b1;
                     bit_q             <= bit_q - 1'b1;
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy_o  <= 1'b0;
            end
         endcase
      end
   end

endmodule

// ===== logic/adc_result_hold_register.v
// Two-channel result holding word with valid/overrun flags and its converter
//
// Local design decision: the Wishbone interface to the registers.
`include "adc_result_defines.vh"

// How it works
// - Channel A's latest 12-bit result sits in word bits 11 to 0.
// - Channel B's latest 12-bit result sits in word bits 27 to 16.
// - Completion sets channel valid flag: bit 15 for A, bit 31 for B.
// - Reading the result word clears both valid and both overrun flags.
// - Loading over an unread result sets overrun: bit 14 A, bit 30 B.
// - Overrun 0 means latest unread result; 1 means one was overwritten.
// - Each finished conversion is written into the converted channel's field.
// - Results have 12-bit resolution from successive approximation.
module adc_result_hold_register #(
   parameter DATA_W      = `RES_DATA_W,
   parameter STEP_CYCLES = `SAR_STEP_CYCLES
) (
   input  wire                   clk_i,
   input  wire                   rst_i,
   // Classic Wishbone slave
   input  wire                   wb_cyc_i,
   input  wire                   wb_stb_i,
   input  wire                   wb_we_i,
   input  wire [`RES_ADDR_W-1:0] wb_adr_i,
   input  wire [3:0]             wb_sel_i,
   input  wire [31:0]            wb_dat_i,
   output reg  [31:0]            wb_dat_o,
   output reg                    wb_ack_o,
   // Conversion requests from the trigger logic, same clock
   input  wire                   start_a_i,
   input  wire                   start_b_i,
   // Analog comparator pin: high when input is at or above the trial code
   input  wire                   cmp_i,
   // Trial code for the DAC and converter activity
   output reg  [DATA_W-1:0]      dac_code_o,
   output reg                    busy_o
);

   // Synchroniser for the comparator pin; the pin may move at any time,
   // so only the second flop is read and a metastable first stage never
   // reaches the search logic
   reg cmp_meta_q;
   reg cmp_sync_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         cmp_meta_q <= 1'b0;
         cmp_sync_q <= 1'b0;
      end else begin
         cmp_meta_q <= cmp_i;
         cmp_sync_q <= cmp_meta_q;
      end
   end

   // Bus decode; writes are acknowledged and dropped, word is read-only.
   // A request is taken on the edge where cyc and stb stand high and no
   // ack is showing; the answer follows one edge later. Masking with the
   // ack keeps a master that holds stb high from being taken twice in a
   // row, which would clear flags before it had seen them.
   // Byte selects and write data are not looked at: the whole word is
   // always returned and nothing here can be written.
   wire req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire hit      = (wb_adr_i == `RES_OFFSET_DUAL);
   wire rd_clear = req & ~wb_we_i & hit;

   // Converter sequencer and channel arbitration
   wire              sar_busy;
   wire              sar_done;
   wire [DATA_W-1:0] sar_code;
   wire [DATA_W-1:0] sar_result;

   reg  [1:0] pend_q;
   reg        chan_q;
   reg        launch_q;

   wire idle_free = ~sar_busy & ~launch_q;
   wire pick_b    = ~pend_q[0];

   // Requests are remembered until served; a new request wins over the
   // service clear so a start arriving while its channel launches is kept
   // as a second conversion rather than lost.
   // Channel A outranks channel B when both wait. A trigger source that
   // keeps channel A pending without a break can hold B off, so the
   // trigger logic must leave gaps between A requests.
   always @(posedge clk_i) begin
      if (rst_i) begin
         pend_q   <= 2'b00;
         chan_q   <= `CHAN_A;
         launch_q <= 1'b0;
      end else begin
         launch_q <= 1'b0;
         if (idle_free && (pend_q != 2'b00)) begin
            chan_q   <= pick_b ? `CHAN_B : `CHAN_A;
            launch_q <= 1'b1;
            pend_q   <= (pick_b ? (pend_q & 2'b01) : (pend_q & 2'b10))
                        | {start_b_i, start_a_i};
         end else begin
            pend_q <= pend_q | {start_b_i, start_a_i};
         end
      end
   end

   sar_sequencer #(
      .DATA_W      (DATA_W),
      .STEP_CYCLES (STEP_CYCLES)
   ) u_sar (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .start_i  (launch_q),
      .cmp_i    (cmp_sync_q),
      .code_o   (sar_code),
      .busy_o   (sar_busy),
      .done_o   (sar_done),
      .result_o (sar_result)
   );

   // Per-channel result, valid and overrun storage
   wire [DATA_W-1:0] res_a;
   wire [DATA_W-1:0] res_b;
   wire [1:0]        valid;
   wire [1:0]        over;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : slot
         reg [DATA_W-1:0] data_q;
         reg [DATA_W-1:0] data_d;
         reg              valid_q;
         reg              valid_d;
         reg              over_q;
         reg              over_d;
         wire             load = sar_done & (chan_q == ch);

         // Next field and flag state; a load outranks a same-cycle read
         // clear so a fresh result is never lost between snapshot and clear
         always @* begin
            data_d  = data_q;
            valid_d = valid_q;
            over_d  = over_q;
            if (load) begin
               data_d  = sar_result;
               valid_d = 1'b1;
               // overrun only if the old result is unread and not read this same cycle
               over_d  = valid_q & ~rd_clear;
            end else if (rd_clear) begin
               valid_d = 1'b0;
               over_d  = 1'b0;
            end
         end

         // Storage of the channel slot
         always @(posedge clk_i) begin
            if (rst_i) begin
               data_q  <= {DATA_W{1'b0}};
               valid_q <= 1'b0;
               over_q  <= 1'b0;
            end else begin
               data_q  <= data_d;
               valid_q <= valid_d;
               over_q  <= over_d;
            end
         end

         assign valid[ch] = valid_q;
         assign over[ch]  = over_q;
      end
   endgenerate

   assign res_a = slot[0].data_q;
   assign res_b = slot[1].data_q;

   // Assembled word; reserved bits 29:28 and 13:12 read as zero.
   // Starting from the reset value keeps the gaps at zero whatever the
   // field widths, so software may compare the word as a whole.
   reg [31:0] word;

   always @* begin
      word = `RES_RESET;
      word[`RES_A_MSB:`RES_A_LSB] = res_a;
      word[`RES_A_OVERRUN_BIT]    = over[0];
      word[`RES_A_VALID_BIT]      = valid[0];
      word[`RES_B_MSB:`RES_B_LSB] = res_b;
      word[`RES_B_OVERRUN_BIT]    = over[1];
      word[`RES_B_VALID_BIT]      = valid[1];
   end

   // One-cycle registered answer; data is captured on the same edge the
   // flags clear, so the reader sees the flags as they stood before.
   // The snapshot moves only on reads, so wb_dat_o keeps the last word
   // read through any number of writes.
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `RES_RESET;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= hit ? word : 32'h00000000;
         end
      end
   end

   // Any request queued, launching or converting counts as activity
   wire work_any = sar_busy | launch_q | (pend_q != 2'b00);

   // Registered copies of converter activity for the pins
   always @(posedge clk_i) begin
      if (rst_i) begin
         dac_code_o <= {DATA_W{1'b0}};
         busy_o     <= 1'b0;
      end else begin
         dac_code_o <= sar_code;
         busy_o     <= work_any;
      end
   end

endmodule

// ===== verification/adc_result_checker.sv
// Port checker for the dual-channel result word and its converter
`include "adc_result_defines.vh"
module adc_result_checker #(
   parameter DATA_W = 12
) (
   input logic              clk_i,
   input logic              rst_i,
   input logic              wb_cyc_i,
   input logic              wb_stb_i,
   input logic              wb_we_i,
   input logic [3:0]        wb_adr_i,
   input logic [31:0]       wb_dat_o,
   input logic              wb_ack_o,
   input logic              start_a_i,
   input logic [DATA_W-1:0] dac_code_o,
   input logic              busy_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A request that is not yet answered
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_follows_req: assert property (req |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_has_cause: assert property (wb_ack_o |-> $past(req))
      else $error("ack without request");
   a_unmapped_zero: assert property (wb_ack_o && $past(!wb_we_i
      && wb_adr_i != 4'h0) |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_gap_bits_zero: assert property (wb_ack_o |->
      wb_dat_o[13:12] == 2'h0 && wb_dat_o[29:28] == 2'h0)
      else $error("reserved bits set");
   a_overrun_a_valid: assert property (wb_ack_o && wb_dat_o[14] |->
      wb_dat_o[15]) else $error("A overrun without valid");
   a_overrun_b_valid: assert property (wb_ack_o && wb_dat_o[30] |->
      wb_dat_o[31]) else $error("B overrun without valid");
   a_data_held: assert property ($changed(wb_dat_o) |-> wb_ack_o)
      else $error("read data changed outside ack");
   a_start_busy: assert property (start_a_i && !busy_o |->
      ##[1:3] busy_o) else $error("start did not raise busy");
   a_dac_msb_first: assert property ($rose(busy_o) |->
      ##2 dac_code_o == 12'h800) else $error("first trial code wrong");
endmodule

bind adc_result_hold_register adc_result_checker #(.DATA_W(DATA_W)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .start_a_i(start_a_i), .dac_code_o(dac_code_o),
   .busy_o(busy_o));

// ===== verification/adc_result_hold_register_tb.sv
// Self-checking bench for the dual-channel result word
module adc_result_hold_register_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i = 1'b0, rst_i = 1'b1, cmp_i;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic        start_a_i = 1'b0, start_b_i = 1'b0, wb_ack_o, busy_o;
   logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, d;
   logic [11:0] dac_code_o, ain = 12'h000;
   int          n_mismatch = 0, num_checks = 0;

   adc_result_hold_register dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .start_a_i(start_a_i),
      .start_b_i(start_b_i), .cmp_i(cmp_i), .dac_code_o(dac_code_o),
      .busy_o(busy_o));

   initial forever #10 clk_i = ~clk_i;
   // Comparator stand-in: a plain analog compare with no clock of its
   // own; the design's registered dac_code_o and its synchroniser supply the only delay
   assign cmp_i = (ain >= dac_code_o);

   task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle, held until ack is sampled high
   task automatic bus(input logic we, input logic [3:0] adr);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= 32'hFFFFFFFF;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      d = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd_chk(input logic [31:0] exp);
      bus(1'b0, 4'h0);
      cmp32(d, exp);
   endtask
   // Pulse the starts, then wait for the converter to go idle
   task automatic conv(input logic [1:0] ch, input logic [11:0] v);
      @(posedge clk_i);
      ain <= v;
      start_a_i <= ch[0];
      start_b_i <= ch[1];
      @(posedge clk_i);
      start_a_i <= 1'b0;
      start_b_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      cmp32({31'h0, busy_o}, 32'h00000001);
      while (busy_o !== 1'b0) begin
         @(posedge clk_i);
      end
      @(posedge clk_i);
      cmp32({20'h0, dac_code_o}, {20'h0, v});
   endtask

   task automatic t_single_a;
      rd_chk(32'h00000000);
      conv(2'h1, 12'hA5C);
      rd_chk(32'h00008A5C);
      rd_chk(32'h00000A5C);
      $display("single A done");
   endtask
   task automatic t_overrun_b;
      conv(2'h2, 12'h3F1);
      conv(2'h2, 12'hFFF);
      rd_chk(32'hCFFF0A5C);
      rd_chk(32'h0FFF0A5C);
      conv(2'h1, 12'h000);
      rd_chk(32'h0FFF8000);
      $display("overrun B done");
   endtask
   // Both queued together; a write and a stray read must not clear flags
   task automatic t_both_refused;
      conv(2'h3, 12'h5A5);
      bus(1'b1, 4'h0);
      bus(1'b0, 4'h4);
      cmp32(d, 32'h00000000);
      rd_chk(32'h85A585A5);
      $display("both and refused done");
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_single_a();
      t_overrun_b();
      t_both_refused();
      finish_test();
   end
   // Run needs about 370 cycles; cut a hang well beyond that
   initial begin
      #100us;
      n_mismatch++;
      finish_test();
   end
endmodule
